// File: hdl/bsw_bcd_digit.v
`include "bsw_stopwatch_regs.vh"

// One decimal digit, 0 to 9, with synchronous clear and a wrap strobe
module bsw_bcd_digit (
   input  wire       ref_clk,
   input  wire       reset,
   input  wire       ce,
   input  wire       clear,
   input  wire       advance,
   output reg  [3:0] digit,
   output wire       wrap
);
   // Clear beats an advance in the same cycle, so no wrap is reported then
   assign wrap = advance & ~clear & (digit == `BSW_DIGIT_MAX);

   always @(posedge ref_clk) begin
      if (reset) begin
         digit <= `BSW_RST_DIGIT;
      end else if (ce) begin
         if (clear) begin
            digit <= `BSW_RST_DIGIT;
         end else if (advance) begin
            if (digit == `BSW_DIGIT_MAX) begin
               digit <= `BSW_RST_DIGIT;
            end else begin
               digit <= digit + 4'h1;
            end
         end
      end
   end
endmodule

// File: hdl/bsw_stopwatch_regs.vh
`ifndef BSW_STOPWATCH_REGS_VH
`define BSW_STOPWATCH_REGS_VH

// Register indices; the byte address on the bus is four times the index
`define BSW_IDX_CONTROL   16'hff7c
`define BSW_IDX_HUNDREDTH 16'hff7d
`define BSW_IDX_TENTH     16'hff7e
`define BSW_IDX_MASK      16'hffe7
`define BSW_IDX_FLAGS     16'hfff7

// Field positions
`define BSW_CTRL_RUN      0
`define BSW_CTRL_CLEAR    1
`define BSW_FLAG_TENHZ    0
`define BSW_FLAG_ONEHZ    1

// Reset values
`define BSW_RST_RUN       1'h0
`define BSW_RST_DIGIT     4'h0
`define BSW_RST_MASK      4'h0
`define BSW_RST_FLAGS     2'h0

// Digit range and base tick pattern
`define BSW_DIGIT_MAX     4'h9
`define BSW_ADV_PER_SEC   9'h064
`define BSW_BASE_PER_SEC  9'h100

// Timing: base tick rate and clock rate in Hz, cycles per base tick
`define BSW_REF_CLK_HZ    10000000
`define BSW_BASE_TICK_HZ  256
// Reference clock over base tick rate, rounded down, sized to the divider
`define BSW_BASE_CYCLES   16'h9896

`endif

// File: hdl/bsw_stopwatch_timer.v
// Decided for this implementation: the Wishbone register port.
`include "bsw_stopwatch_regs.vh"

// Functional notes
// - Two cascaded four-bit decimal digits, hundredths and tenths, each counting 0 to 9.
// - Hundredths advance on a 256 Hz base, two or three base ticks apart.
// - Each hundredths wrap is a 10 Hz carry, the only count clock of tenths.
// - Per second four decades last 25 ticks, six last 26; tenths wrap at 1 Hz.
// - Hundredths wrap sets the 10 Hz flag; tenths wrap sets the 1 Hz flag.
// - Flags set on overflow regardless of mask; mask only gates the request.
// - Mask bit 0 enables 10 Hz, bit 1 enables 1 Hz; both clear at reset.
// - Writing one clears a flag, zero leaves it; read shows a pending overflow.
// - Both digit registers are read-only BCD values; writes have no effect.
// - Software reads the count one four-bit digit per access.
// - Both digits reset to zero.
// - Writing one to control bit 1 clears both digits; reads as zero.
// - Clear written with bit 0 at one resumes from zero at once; with bit 0 at zero, zero holds.
// - Control bit 0 runs on one, stops on zero, reads back, resets to zero.
// - Stopped digits hold; running again continues from the held value.
// - Bits 3 and 2 of control and flag registers read as zero.
module bsw_stopwatch_timer #(
   parameter [15:0] BASE_CYCLES = `BSW_BASE_CYCLES
) (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        ce,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [17:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         tenHzIrq,
   output reg         oneHzIrq,
   output reg         irq
);
   reg        run;
   reg [7:0]  phaseAcc;
   reg [3:0]  maskReg;
   reg [1:0]  flags;
   wire       baseTick;
   wire       busReq;
   wire       wrLow;
   wire [15:0] regIdx;
   wire       clearReq;
   wire [8:0] phaseSum;
   wire       hundAdvance;
   wire       tenthAdvance;
   wire       tenthWrap;
   wire [3:0] hundDigit;
   wire [3:0] tenthDigit;
   reg [31:0] next_rdData;
   reg [1:0]  next_flags;

   // A new request is taken on the edge where ack is raised
   assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Registers are four bits wide and live in byte lane 0 only
   assign wrLow  = busReq & wb_we_i & wb_sel_i[0];
   assign regIdx = wb_adr_i[17:2];

   // Clear strobe lasts the one cycle of the write
   assign clearReq = wrLow & (regIdx == `BSW_IDX_CONTROL) &
                     wb_dat_i[`BSW_CTRL_CLEAR];

   // Base tick at 256 Hz from the reference clock
   bsw_tick_div #(
      .DIV_CYCLES (BASE_CYCLES)
   ) u_tickDiv (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .ce       (ce),
      .baseTick (baseTick)
   );

   // Adding 100 per base tick in an 8-bit phase gives exactly 100 carries per
   // 256 ticks, spaced 2 or 3 apart; decades then fall out as 25 or 26 ticks
   // in a 4:6 mix, so the tenths wrap lands on every 256th tick
   assign phaseSum    = {1'b0, phaseAcc} + `BSW_ADV_PER_SEC;
   assign hundAdvance = run & baseTick & phaseSum[8];

   always @(posedge ref_clk) begin
      if (reset) begin
         phaseAcc <= 8'h00;
      end else if (ce) begin
         if (clearReq) begin
            phaseAcc <= 8'h00;
         end else if (run & baseTick) begin
            phaseAcc <= phaseSum[7:0];
         end
      end
   end

   // Hundredths digit, fed by the approximate 100 Hz advance
   bsw_bcd_digit u_hund (
      .ref_clk (ref_clk),
      .reset   (reset),
      .ce      (ce),
      .clear   (clearReq),
      .advance (hundAdvance),
      .digit   (hundDigit),
      .wrap    (tenthAdvance)
   );

   // Tenths digit counts only the hundredths carry
   bsw_bcd_digit u_tenth (
      .ref_clk (ref_clk),
      .reset   (reset),
      .ce      (ce),
      .clear   (clearReq),
      .advance (tenthAdvance),
      .digit   (tenthDigit),
      .wrap    (tenthWrap)
   );

   // Run bit; a stop only gates the advance, so digits and phase are kept
   always @(posedge ref_clk) begin
      if (reset) begin
         run <= `BSW_RST_RUN;
      end else if (ce) begin
         if (wrLow & (regIdx == `BSW_IDX_CONTROL)) begin
            run <= wb_dat_i[`BSW_CTRL_RUN];
         end
      end
   end

   // Mask register; upper two bits are spare storage
   always @(posedge ref_clk) begin
      if (reset) begin
         maskReg <= `BSW_RST_MASK;
      end else if (ce) begin
         if (wrLow & (regIdx == `BSW_IDX_MASK)) begin
            maskReg <= wb_dat_i[3:0];
         end
      end
   end

   // Sticky flags: write-one clears, but an overflow in the same cycle wins
   always @* begin
      next_flags = flags;
      if (wrLow & (regIdx == `BSW_IDX_FLAGS)) begin
         next_flags = flags & ~wb_dat_i[1:0];
      end
      if (tenthAdvance) begin
         next_flags[`BSW_FLAG_TENHZ] = 1'b1;
      end
      if (tenthWrap) begin
         next_flags[`BSW_FLAG_ONEHZ] = 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         flags <= `BSW_RST_FLAGS;
      end else if (ce) begin
         flags <= next_flags;
      end
   end

   // Requests follow the flags that will stand next cycle, so they are
   // registered and still line up with the flag they belong to
   always @(posedge ref_clk) begin
      if (reset) begin
         tenHzIrq <= 1'b0;
         oneHzIrq <= 1'b0;
         irq      <= 1'b0;
      end else if (ce) begin
         tenHzIrq <= next_flags[`BSW_FLAG_TENHZ] & maskReg[`BSW_FLAG_TENHZ];
         oneHzIrq <= next_flags[`BSW_FLAG_ONEHZ] & maskReg[`BSW_FLAG_ONEHZ];
         irq      <= |(next_flags & maskReg[1:0]);
      end
   end

   // Read mux; unmapped addresses and unused bits read as zero
   always @* begin
      next_rdData = 32'h00000000;
      case (regIdx)
         `BSW_IDX_CONTROL: begin
            next_rdData[`BSW_CTRL_RUN] = run;
         end
         `BSW_IDX_HUNDREDTH: begin
            next_rdData[3:0] = hundDigit;
         end
         `BSW_IDX_TENTH: begin
            next_rdData[3:0] = tenthDigit;
         end
         `BSW_IDX_MASK: begin
            next_rdData[3:0] = maskReg;
         end
         `BSW_IDX_FLAGS: begin
            next_rdData[1:0] = flags;
         end
         default: begin
            next_rdData = 32'h00000000;
         end
      endcase
   end

   // One wait state: ack one cycle after the request, dropped the next cycle
   always @(posedge ref_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce) begin
         wb_ack_o <= busReq;
         if (busReq & ~wb_we_i) begin
            wb_dat_o <= next_rdData;
         end
      end
   end
endmodule

// File: hdl/bsw_tick_div.v
// Divides the reference clock down to the 256 Hz base tick pulse
module bsw_tick_div #(
   parameter [15:0] DIV_CYCLES = 16'h9896
) (
   input  wire ref_clk,
   input  wire reset,
   input  wire ce,
   output reg  baseTick
);
   reg [15:0] divCount;

   // Free running; the stopwatch gates its use of the tick, not the divider
   always @(posedge ref_clk) begin
      if (reset) begin
         divCount <= 16'h0000;
         baseTick <= 1'b0;
      end else if (ce) begin
         if (divCount >= DIV_CYCLES - 16'h0001) begin
            divCount <= 16'h0000;
            baseTick <= 1'b1;
         end else begin
            divCount <= divCount + 16'h0001;
            baseTick <= 1'b0;
         end
      end
   end
endmodule

// File: tb/bsw_timer_monitor.sv
`include "bsw_stopwatch_regs.vh"

// Watches the bus and the request outputs of the stopwatch block
module bsw_timer_monitor #(
   parameter [15:0] BASE_CYCLES = 16'h0004
) (
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        ce,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        tenHzIrq,
   input wire logic        oneHzIrq,
   input wire logic        irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // A request counts only while ack is low, so a held request is not taken twice
   wire        take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   wire        wrTake = take && wb_we_i && wb_sel_i[0];
   wire [15:0] idx = wb_adr_i[17:2];
   sequence sRead(a);
      take && !wb_we_i && idx == a;
   endsequence
   sequence sAnswer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_ack_answer: assert property (take |=> sAnswer)
      else $error("request not answered by one ack");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
      else $error("ack without request");
   chk_ctrl_zero: assert property (
      sRead(`BSW_IDX_CONTROL) |=> wb_dat_o[31:1] == 31'h0)
      else $error("control read shows clear or unused bits");
   chk_flag_zero: assert property (
      sRead(`BSW_IDX_FLAGS) |=> wb_dat_o[31:2] == 30'h0)
      else $error("flag read shows unused bits");
   chk_digit_bcd: assert property (
      (sRead(`BSW_IDX_HUNDREDTH) or sRead(`BSW_IDX_TENTH)) |=> wb_dat_o <= 32'h9)
      else $error("digit outside 0 to 9");
   chk_irq_or: assert property (irq == (tenHzIrq || oneHzIrq))
      else $error("irq differs from the two requests");
   chk_mask_gate: assert property (
      (wrTake && idx == `BSW_IDX_MASK && wb_dat_i[1:0] == 2'h0) |-> ##[1:3] !irq)
      else $error("request stays up after masking");
   chk_irq_drop: assert property (
      ($fell(tenHzIrq) || $fell(oneHzIrq)) |-> ($past(wrTake) || $past(wrTake, 2)))
      else $error("request dropped without a write");
endmodule

bind bsw_stopwatch_timer bsw_timer_monitor #(.BASE_CYCLES(BASE_CYCLES)) i_mon (
   .ref_clk(ref_clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tenHzIrq(tenHzIrq), .oneHzIrq(oneHzIrq),
   .irq(irq)
);

// File: tb/tb_bsw_stopwatch_timer.sv
`include "bsw_stopwatch_regs.vh"

module tb_bsw_stopwatch_timer;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] CT = `BSW_IDX_CONTROL;
   localparam logic [15:0] HU = `BSW_IDX_HUNDREDTH;
   localparam logic [15:0] TE = `BSW_IDX_TENTH;
   localparam logic [15:0] MA = `BSW_IDX_MASK;
   localparam logic [15:0] FL = `BSW_IDX_FLAGS;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [17:0] adr = 18'h0;
   logic [31:0] dat = 32'h0;
   wire  [31:0] datOut;
   wire         ack, tenIrq, oneIrq, irq;
   int          errors = 0;
   int          checked = 0;
   int          n10, n1;
   logic [31:0] q, h;
   // 10 MHz clock
   always #50 ref_clk = ~ref_clk;
   // Short base tick keeps one second at 1024 clocks
   bsw_stopwatch_timer #(.BASE_CYCLES(16'h0004)) i_dut (
      .ref_clk(ref_clk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(datOut),
      .wb_ack_o(ack), .tenHzIrq(tenIrq), .oneHzIrq(oneIrq), .irq(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One classic cycle; waits for ack, then leaves one idle cycle
   task automatic bus(input logic w, input logic [15:0] i, input logic [3:0] d,
                      output logic [31:0] r);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'h0};
      dat <= {28'h0, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      // A missing ack is a failure, not a silent pass
      if (ack !== 1'b1) errors++;
      r = datOut;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [15:0] i, input logic [31:0] exp);
      bus(1'b0, i, 4'h0, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [15:0] i, input logic [3:0] d);
      bus(1'b1, i, d, q);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic end_of_test;
      $display("%0d comparisons, %0d mismatches", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Cuts a hang short
   initial begin
      tick(20000);
      errors++;
      end_of_test;
   end
   initial begin
      tick(5);
      reset <= 1'b0;
      tick(1);
      rd(CT, 0);
      rd(HU, 0);
      rd(TE, 0);
      rd(MA, 0);
      rd(FL, 0);
      wr(16'h0000, 4'h5);
      rd(16'h0000, 0);
      wr(MA, 4'hf);
      rd(MA, 32'hf);
      wr(HU, 4'h5);
      rd(HU, 0);
      $display("test access done");
      wr(CT, 4'h1);
      n10 = 0;
      while (tenIrq !== 1'b1 && n10 < 2000) begin
         tick(1);
         n10++;
      end
      n1 = n10;
      while (oneIrq !== 1'b1 && n1 < 2000) begin
         tick(1);
         n1++;
      end
      chk(n10 >= 96 && n10 <= 112, 1);
      chk(n1 >= 1016 && n1 <= 1032, 1);
      rd(CT, 1);
      rd(FL, 3);
      chk(irq, 1);
      chk(tenIrq, 1);
      chk(oneIrq, 1);
      wr(MA, 4'h0);
      chk(irq, 0);
      chk(tenIrq, 0);
      chk(oneIrq, 0);
      $display("test count done");
      wr(CT, 4'h0);
      bus(1'b0, HU, 4'h0, h);
      tick(100);
      rd(HU, h);
      wr(FL, 4'h1);
      rd(FL, 2);
      wr(FL, 4'h0);
      rd(FL, 2);
      wr(FL, 4'h2);
      wr(CT, 4'h2);
      rd(CT, 0);
      tick(60);
      rd(HU, 0);
      wr(CT, 4'h1);
      tick(500);
      rd(FL, 1);
      chk(irq, 0);
      chk(tenIrq, 0);
      wr(CT, 4'h3);
      rd(HU, 0);
      rd(TE, 0);
      tick(40);
      bus(1'b0, HU, 4'h0, h);
      chk(h >= 2 && h <= 4, 1);
      // Stop, read both digits, restart; the count must carry on from the held value
      wr(CT, 4'h0);
      bus(1'b0, HU, 4'h0, h);
      rd(TE, 0);
      wr(CT, 4'h1);
      tick(20);
      wr(CT, 4'h0);
      bus(1'b0, HU, 4'h0, q);
      chk(q > h && q <= h + 32'h3, 1);
      $display("test clear done");
      end_of_test;
   end
endmodule
